// ---- logic/dmc_map.vh ----
`ifndef DMC_MAP_VH
`define DMC_MAP_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define DMC_CTRL_INDEX 12'h0c6
`define DMC_CTRL_ADDR 12'h318
`define DMC_STAT_INDEX 12'h0c7
`define DMC_STAT_ADDR 12'h31c

// ----------------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------------
`define DMC_CTRL_RESET 16'h0000
`define DMC_CTRL_WMASK 16'h3fec
`define DMC_WS_HI 13
`define DMC_WS_LO 10
`define DMC_BURST_ALLOW_BIT 9
`define DMC_AA_BIT 8
`define DMC_PS_HI 7
`define DMC_PS_LO 6
`define DMC_EXT_MASTER_AUTO_ACK_ENABLE_BIT 5
`define DMC_WRITE_ADDR_HOLD_ENABLE_BIT 3
`define DMC_READ_ADDR_HOLD_ENABLE_BIT 2

// ----------------------------------------------------------------------------
// Port width and transfer size encodings
// ----------------------------------------------------------------------------
`define DMC_PS_32 2'h0
`define DMC_PS_8 2'h1
`define DMC_SIZE_LONG 2'h0
`define DMC_SIZE_BYTE 2'h1
`define DMC_SIZE_WORD 2'h2
`define DMC_SIZE_LINE 2'h3

`endif

// ---- logic/dmc_wait_timer.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Wait-state down counter
// ----------------------------------------------------------------------------
module dmc_wait_timer #(
    parameter WIDTH = 4
) (
    input wire clk_in,
    input wire rst_in,
    input wire load_in,
    input wire [WIDTH-1:0] count_in,
    input wire run_in,
    output wire done_out
);
    reg [WIDTH-1:0] count;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= {WIDTH{1'b0}};
        end else if (load_in) begin
            count <= count_in;
        end else if (run_in && count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done_out = (count == {WIDTH{1'b0}});
endmodule

`default_nettype wire

// ---- logic/dmc_default_memory.v ----
// Behaviour
// - Core access with auto-acknowledge ends internally after the programmed wait states.
// - An external acknowledge before the wait count elapses ends the cycle at once.
// - External-master auto-acknowledge inserts the wait states before asserting acknowledge.
// - Without burst allow, wide transfers split into non-burst transfers of port width.
// - With burst allow, wide transfers run as one burst, line transfers included.
// - Core auto-acknowledge cleared: core accesses wait for an external acknowledge.
// - Core auto-acknowledge set: core accesses end with internal acknowledge after waits.
// - With core auto-acknowledge, a default-memory core access completes normally unless transfer error acknowledge ends it with an error.
// - Port-width field picks lanes: 00 32-bit, 01 8-bit high, 1x 16-bit high.
// - External-master auto-acknowledge cleared: acknowledge pin is not driven.
// - External-master auto-acknowledge set: device drives acknowledge pin after waits.
// - External-master default-memory accesses complete normally under auto-acknowledge.
// - Write address hold adds one cycle after each beat outside a burst; after the last it keeps address, byte lanes and write, and data only on a 32-bit port.
// - Read address hold adds one cycle after each beat outside a burst; only after the last does it keep the address and byte lanes.
// - These settings apply only to accesses outside chip-select and DRAM regions.
// - Reset clears the whole control register to zero.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.vh"
module dmc_default_memory #(
    parameter WS_WIDTH = 4
) (
    input wire clk_in,
    input wire rst_in,
    // AHB-Lite register slave.
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire hreadyout_out,
    output wire hresp_out,
    output wire [31:0] hrdata_out,
    // Core request side.
    input wire core_req_in,
    input wire core_region_hit_in,
    input wire [31:0] core_addr_in,
    input wire [1:0] core_size_in,
    input wire core_write_in,
    input wire [31:0] core_wdata_in,
    output reg core_ack_out,
    output reg core_err_out,
    output reg core_last_out,
    output reg [31:0] core_rdata_out,
    // External bus pins.
    output wire [31:0] ext_addr_out,
    output wire ext_addr_valid_out,
    output wire ext_ts_out,
    output wire ext_cycle_out,
    output wire ext_write_out,
    output wire [1:0] ext_size_out,
    output wire ext_burst_out,
    output wire [3:0] ext_lane_out,
    output wire [31:0] ext_data_out,
    output wire ext_data_oe_out,
    input wire [31:0] ext_data_in,
    input wire transfer_acknowledge_pin_in,
    output reg transfer_acknowledge_pin_out,
    output reg transfer_acknowledge_pin_oe_out,
    input wire async_transfer_acknowledge_pin_in,
    input wire transfer_error_acknowledge_pin_in,
    // External master cycle to the bus.
    input wire em_req_in,
    input wire em_region_hit_in
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam C_IDLE = 2'd0, C_ADDR = 2'd1, C_DATA = 2'd2, C_HOLD = 2'd3;
    localparam E_IDLE = 2'd0, E_WAIT = 2'd1, E_ACK = 2'd2, E_DONE = 2'd3;
    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    reg [15:0] default_memory_control;
    reg dp_write, dp_read, last_error;
    reg [11:0] dp_addr;
    reg [1:0] cstate, estate;
    wire [WS_WIDTH-1:0] wait_state_count = default_memory_control[`DMC_WS_HI:`DMC_WS_LO];
    wire burst_allow = default_memory_control[`DMC_BURST_ALLOW_BIT];
    wire core_auto_ack_enable = default_memory_control[`DMC_AA_BIT];
    wire [1:0] port_width_sel = default_memory_control[`DMC_PS_HI:`DMC_PS_LO];
    wire ext_master_auto_ack_enable = default_memory_control[`DMC_EXT_MASTER_AUTO_ACK_ENABLE_BIT];
    wire write_addr_hold_enable = default_memory_control[`DMC_WRITE_ADDR_HOLD_ENABLE_BIT];
    wire read_addr_hold_enable = default_memory_control[`DMC_READ_ADDR_HOLD_ENABLE_BIT];
    wire addr_phase = hsel_in && htrans_in[1] && hready_in;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {dp_write, dp_read, dp_addr} <= 14'h0000;
        end else if (hready_in) begin
            dp_write <= addr_phase && hwrite_in;
            dp_read <= addr_phase && !hwrite_in;
            dp_addr <= haddr_in[11:0];
        end
    end
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            default_memory_control <= `DMC_CTRL_RESET;
        end else if (dp_write && dp_addr == `DMC_CTRL_ADDR) begin
            default_memory_control <= hwdata_in[15:0] & `DMC_CTRL_WMASK;
        end
    end
    // Status shows both masters' activity, the hold phase and the last outcome.
    wire [31:0] status_word = {28'h0000000, (cstate == C_HOLD), last_error,
                               (estate != E_IDLE), (cstate != C_IDLE)};
    assign hrdata_out = !dp_read ? 32'h00000000 :
                        (dp_addr == `DMC_CTRL_ADDR) ? {16'h0000, default_memory_control} :
                        (dp_addr == `DMC_STAT_ADDR) ? status_word : 32'h00000000;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    // ------------------------------------------------------------------------
    // Transfer geometry
    // ------------------------------------------------------------------------
    reg [31:0] addr, wdata, rdata;
    reg [1:0] size, ps;
    reg wr, burst, aa, hold_en;
    reg [4:0] beats_left, beat_idx, word_mask;
    // Port and operand widths in bytes as powers of two, beat count, and beats per longword less one.
    reg [2:0] port_log, size_log;
    reg [4:0] start_beats, start_word_mask;
    always @* begin
        case (port_width_sel)
            `DMC_PS_32: port_log = 3'd2;
            `DMC_PS_8: port_log = 3'd0;
            default: port_log = 3'd1;
        endcase
        case (core_size_in)
            `DMC_SIZE_BYTE: size_log = 3'd0;
            `DMC_SIZE_WORD: size_log = 3'd1;
            `DMC_SIZE_LONG: size_log = 3'd2;
            default: size_log = 3'd4;
        endcase
        if (size_log > port_log) begin
            start_beats = 5'd1 << (size_log - port_log);
        end else begin
            start_beats = 5'd1;
        end
        start_word_mask = (5'd1 << (3'd2 - port_log)) - 5'd1;
    end
    wire [31:0] port_step = (ps == `DMC_PS_32) ? 32'h00000004 :
                            (ps == `DMC_PS_8) ? 32'h00000001 : 32'h00000002;
    // Byte lanes that carry valid data in this beat.
    reg [3:0] lanes;
    always @* begin
        case (ps)
            `DMC_PS_32: begin
                if (size == `DMC_SIZE_BYTE) begin
                    lanes = 4'h8 >> addr[1:0];
                end else if (size == `DMC_SIZE_WORD) begin
                    lanes = addr[1] ? 4'h3 : 4'hc;
                end else begin
                    lanes = 4'hf;
                end
            end
            `DMC_PS_8: lanes = 4'h8;
            default: begin
                if (size == `DMC_SIZE_BYTE) begin
                    lanes = addr[0] ? 4'h4 : 4'h8;
                end else begin
                    lanes = 4'hc;
                end
            end
        endcase
    end
    // Read portion of the data bus, right-justified.
    reg [31:0] beat_value, next_rdata;
    always @* begin
        case (ps)
            `DMC_PS_32: begin
                if (size == `DMC_SIZE_BYTE) begin
                    beat_value = {24'h000000, ext_data_in[31 - 8 * addr[1:0] -: 8]};
                end else if (size == `DMC_SIZE_WORD) begin
                    beat_value = {16'h0000, addr[1] ? ext_data_in[15:0] : ext_data_in[31:16]};
                end else begin
                    beat_value = ext_data_in;
                end
                next_rdata = beat_value;
            end
            `DMC_PS_8: begin
                beat_value = {24'h000000, ext_data_in[31:24]};
                next_rdata = {rdata[23:0], ext_data_in[31:24]};
            end
            default: begin
                if (size == `DMC_SIZE_BYTE) begin
                    beat_value = {24'h000000,
                                  addr[0] ? ext_data_in[23:16] : ext_data_in[31:24]};
                    next_rdata = beat_value;
                end else begin
                    beat_value = {16'h0000, ext_data_in[31:16]};
                    next_rdata = {rdata[15:0], ext_data_in[31:16]};
                end
            end
        endcase
    end
    // Narrow operands are replicated so the first beat always finds them high.
    reg [31:0] load_wdata;
    always @* begin
        case (size)
            `DMC_SIZE_BYTE: load_wdata = {4{core_wdata_in[7:0]}};
            `DMC_SIZE_WORD: load_wdata = {2{core_wdata_in[15:0]}};
            default: load_wdata = core_wdata_in;
        endcase
    end
    // ------------------------------------------------------------------------
    // Core cycle sequencer
    // ------------------------------------------------------------------------
    wire timer_done;
    wire ext_ack = transfer_acknowledge_pin_in || async_transfer_acknowledge_pin_in;
    wire ext_err = transfer_error_acknowledge_pin_in;
    wire auto_ack = aa && timer_done;
    wire beat_end = (cstate == C_DATA) && (ext_err || ext_ack || auto_ack);
    wire last_beat = (beats_left == 5'd1);
    wire word_end = ((beat_idx & word_mask) == word_mask);
    wire core_start = core_req_in && !core_region_hit_in && !em_req_in
                      && (estate == E_IDLE);
    dmc_wait_timer #(
        .WIDTH(WS_WIDTH)
    ) u_core_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(cstate == C_ADDR || (beat_end && burst)),
        .count_in(wait_state_count),
        .run_in(cstate == C_DATA),
        .done_out(timer_done)
    );
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {cstate, addr, size, wr, burst, ps, wdata, rdata} <= 104'h0;
            {beats_left, beat_idx, word_mask, aa, hold_en, last_error} <= 18'h00000;
            {core_ack_out, core_err_out, core_last_out, core_rdata_out} <= 35'h0;
        end else begin
            core_ack_out <= 1'b0;
            core_err_out <= 1'b0;
            core_last_out <= 1'b0;
            case (cstate)
                C_IDLE: begin
                    if (core_start) begin
                        cstate <= C_ADDR;
                        addr <= core_addr_in;
                        size <= core_size_in;
                        wr <= core_write_in;
                        ps <= port_width_sel;
                        beats_left <= start_beats;
                        beat_idx <= 5'd0;
                        word_mask <= (start_beats == 5'd1) ? 5'd0 : start_word_mask;
                        burst <= burst_allow && (start_beats != 5'd1);
                        aa <= core_auto_ack_enable;
                        hold_en <= core_write_in ? write_addr_hold_enable
                                                 : read_addr_hold_enable;
                    end
                end
                C_ADDR: begin
                    cstate <= C_DATA;
                    if ((beat_idx & word_mask) == 5'd0) begin
                        wdata <= load_wdata;
                    end
                end
                C_DATA: begin
                    if (beat_end) begin
                        rdata <= next_rdata;
                        addr <= addr + port_step;
                        beats_left <= beats_left - 5'd1;
                        beat_idx <= beat_idx + 5'd1;
                        wdata <= (ps == `DMC_PS_8) ? {wdata[23:0], 8'h00} :
                                 (ps == `DMC_PS_32) ? wdata : {wdata[15:0], 16'h0000};
                        if (ext_err) begin
                            core_err_out <= 1'b1;
                            core_last_out <= 1'b1;
                            last_error <= 1'b1;
                        end else if (word_end || last_beat) begin
                            core_ack_out <= 1'b1;
                            core_rdata_out <= next_rdata;
                            core_last_out <= last_beat;
                            last_error <= 1'b0;
                        end
                        // An error ends the whole transfer, split or burst.
                        if (ext_err || last_beat) begin
                            addr <= addr;
                            cstate <= hold_en ? C_HOLD : C_IDLE;
                        end else if (burst) begin
                            cstate <= C_DATA;
                        end else begin
                            cstate <= hold_en ? C_HOLD : C_ADDR;
                        end
                    end
                end
                default: begin
                    cstate <= (beats_left == 5'd0 || core_err_out) ? C_IDLE : C_ADDR;
                    if (core_err_out) begin
                        beats_left <= 5'd0;
                    end
                end
            endcase
        end
    end
    // Split beats use the port size; bursts and single beats keep the operand size.
    wire [1:0] beat_size = (beats_left == 5'd0 || burst || beat_idx == 5'd0 && word_mask == 5'd0
                        && !(size == `DMC_SIZE_LINE)) ? size :
                       (ps == `DMC_PS_8) ? `DMC_SIZE_BYTE :
                       (ps == `DMC_PS_32) ? `DMC_SIZE_LONG : `DMC_SIZE_WORD;
    assign ext_addr_out = addr;
    assign ext_addr_valid_out = (cstate != C_IDLE);
    assign ext_ts_out = (cstate == C_ADDR);
    assign ext_cycle_out = (cstate == C_ADDR) || (cstate == C_DATA);
    assign ext_write_out = wr && (cstate != C_IDLE);
    assign ext_size_out = beat_size;
    assign ext_burst_out = burst && ext_cycle_out;
    assign ext_lane_out = (cstate == C_IDLE) ? 4'h0 : lanes;
    assign ext_data_out = wdata;
    assign ext_data_oe_out = wr && (cstate != C_IDLE);
    // ------------------------------------------------------------------------
    // External master acknowledge
    // ------------------------------------------------------------------------
    wire em_timer_done;
    wire em_start = em_req_in && !em_region_hit_in && ext_master_auto_ack_enable
                    && (cstate == C_IDLE);
    dmc_wait_timer #(
        .WIDTH(WS_WIDTH)
    ) u_em_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(estate == E_IDLE),
        .count_in(wait_state_count),
        .run_in(estate == E_WAIT),
        .done_out(em_timer_done)
    );
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {estate, transfer_acknowledge_pin_out, transfer_acknowledge_pin_oe_out} <= 4'h0;
        end else begin
            case (estate)
                E_IDLE: begin
                    transfer_acknowledge_pin_out <= 1'b0;
                    if (em_start) begin
                        estate <= E_WAIT;
                        transfer_acknowledge_pin_oe_out <= 1'b1;
                    end else begin
                        transfer_acknowledge_pin_oe_out <= 1'b0;
                    end
                end
                E_WAIT: begin
                    if (!em_req_in) begin
                        estate <= E_IDLE;
                        transfer_acknowledge_pin_oe_out <= 1'b0;
                    end else if (em_timer_done) begin
                        estate <= E_ACK;
                        transfer_acknowledge_pin_out <= 1'b1;
                    end
                end
                E_ACK: begin
                    estate <= E_DONE;
                    transfer_acknowledge_pin_out <= 1'b0;
                end
                default: begin
                    if (!em_req_in) begin
                        estate <= E_IDLE;
                        transfer_acknowledge_pin_oe_out <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- bench/dmc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Memory that answers dly_in cycles after the address cycle.
module dmc_mem_model #(
    parameter logic [31:0] DATA = 32'h5ac3_3c5a
) (
    input wire logic clk_in, ts_in, cycle_in, ta_oe_in, err_in,
    input wire logic [3:0] dly_in,
    output logic ta_out, tea_out,
    output logic [31:0] data_out
);
    logic [3:0] n = 4'h0;
    logic [31:0] pat = 32'h0;
    logic hit;
    always @(posedge clk_in) begin
        n <= ts_in ? 4'h1 : n + 4'h1;
        pat <= ~pat;
    end
    assign hit = cycle_in && !ts_in && dly_in != 4'h0 && n == dly_in;
    assign ta_out = hit && !err_in && !ta_oe_in;
    assign tea_out = hit && err_in;
    // Outside an acknowledge the bus is not driven, so it shows a changing pattern.
    assign data_out = ta_out ? DATA : pat;
endmodule
`default_nettype wire

// ---- bench/dmc_default_memory_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.vh"
module dmc_default_memory_chk (
    input wire logic clk_in, rst_in, hsel_in, hwrite_in, hready_in,
    input wire logic [31:0] haddr_in, hwdata_in, ext_addr_out,
    input wire logic [1:0] htrans_in,
    input wire logic core_req_in, core_region_hit_in, core_ack_out, core_last_out,
    input wire logic ext_addr_valid_out, ext_ts_out, ext_cycle_out, ext_write_out,
    input wire logic ext_burst_out, ext_data_oe_out, em_req_in, em_region_hit_in,
    input wire logic [3:0] ext_lane_out,
    input wire logic transfer_acknowledge_pin_in, transfer_acknowledge_pin_out,
    input wire logic transfer_acknowledge_pin_oe_out, async_transfer_acknowledge_pin_in,
    input wire logic transfer_error_acknowledge_pin_in
);
    logic [15:0] ctl;
    logic [7:0] c;
    logic [4:0] w;
    logic wp, xa, bu, ta, oe, tao;
    assign ta = transfer_acknowledge_pin_in;
    assign oe = transfer_acknowledge_pin_oe_out;
    assign tao = transfer_acknowledge_pin_out;
    // Control register copy and counts since the address cycle.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {ctl, c, w, wp, xa, bu} <= '0;
        end else begin
            wp <= hsel_in && htrans_in[1] && hready_in && hwrite_in
                && haddr_in[11:0] == `DMC_CTRL_ADDR;
            if (wp) ctl <= hwdata_in[15:0] & `DMC_CTRL_WMASK;
            c <= ext_ts_out ? 8'h0 : c + 8'h1;
            xa <= !ext_ts_out && (xa || ta || async_transfer_acknowledge_pin_in
                || transfer_error_acknowledge_pin_in);
            bu <= ext_ts_out ? ext_burst_out : bu;
            w <= oe ? w + {4'h0, !tao} : 5'h0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_auto; core_ack_out && ctl[8] && !xa && !bu |-> c == {4'h0, ctl[13:10]} + 8'h1;
    endproperty
    a_auto: assert property (p_auto) else $error("auto ack timing");
    property p_ext; ext_cycle_out && !ext_ts_out && ta && ext_lane_out == 4'hf && !bu
        |=> core_ack_out; endproperty
    a_ext: assert property (p_ext) else $error("early acknowledge ignored");
    property p_noaa; ext_cycle_out && !ctl[8] && !xa && !ta && !async_transfer_acknowledge_pin_in
        && !transfer_error_acknowledge_pin_in |=> !core_ack_out; endproperty
    a_noaa: assert property (p_noaa) else $error("ack without acknowledge");
    property p_lane; ext_cycle_out && ctl[7:6] != 2'h0 |-> ext_lane_out[1:0] == 2'h0
        && ext_lane_out[3] && (ctl[7] || ext_lane_out[2] == 1'b0); endproperty
    a_lane: assert property (p_lane) else $error("wrong byte lanes");
    property p_burst_allow; ext_cycle_out && !ctl[9] |-> !ext_burst_out; endproperty
    a_burst_allow: assert property (p_burst_allow) else $error("burst not allowed");
    property p_hold; $fell(ext_cycle_out) && core_last_out
        |-> ext_addr_valid_out == ($past(ext_write_out) ? ctl[3] : ctl[2]); endproperty
    a_hold: assert property (p_hold) else $error("hold cycle wrong");
    property p_keep; $fell(ext_cycle_out) && core_last_out && ext_addr_valid_out
        |-> $stable(ext_addr_out) && ext_data_oe_out == $past(ext_write_out); endproperty
    a_keep: assert property (p_keep) else $error("hold lost address");
    property p_emon; $rose(em_req_in) && !em_region_hit_in && ctl[5] && !ext_addr_valid_out
        |=> oe [*2]; endproperty
    a_emon: assert property (p_emon) else $error("acknowledge pin not driven");
    property p_emoff; oe |-> ctl[5]; endproperty
    a_emoff: assert property (p_emoff) else $error("acknowledge pin driven");
    property p_emws; tao |-> oe && w > {1'b0, ctl[13:10]}; endproperty
    a_emws: assert property (p_emws) else $error("too few wait states");
    property p_reg; core_req_in && core_region_hit_in && !ext_addr_valid_out |=> !ext_ts_out;
    endproperty
    a_reg: assert property (p_reg) else $error("region access started");
    c_split: cover property (ext_ts_out && ctl[7:6] == 2'h1);
    c_em: cover property (tao);
    c_hold: cover property ($fell(ext_cycle_out) && ext_addr_valid_out);
endmodule
bind dmc_default_memory dmc_default_memory_chk u_dmc_default_memory_chk (.*);
`default_nettype wire

// ---- bench/dmc_default_memory_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmc_default_memory_tb;
    localparam logic [31:0] CTRL = 32'h318, DATA = 32'h5ac3_3c5a;
    logic clk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, hready_in, hreadyout_out;
    logic hresp_out, core_req_in = 0, core_region_hit_in = 0, core_write_in = 0;
    logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, core_rdata_out, ext_addr_out;
    logic [31:0] core_addr_in = 32'h100, core_wdata_in = 32'h1234_5678, ext_data_out;
    logic [31:0] ext_data_in, q;
    logic [1:0] htrans_in = 0, core_size_in = 0, ext_size_out;
    logic [2:0] hsize_in = 3'h2;
    logic [3:0] ext_lane_out, mdly = 0;
    logic core_ack_out, core_err_out, core_last_out, ext_addr_valid_out, ext_ts_out;
    logic ext_cycle_out, ext_write_out, ext_burst_out, ext_data_oe_out, mta, merr = 0;
    logic transfer_acknowledge_pin_in, transfer_acknowledge_pin_out;
    logic transfer_acknowledge_pin_oe_out, transfer_error_acknowledge_pin_in;
    logic async_transfer_acknowledge_pin_in = 0, em_req_in = 0, em_region_hit_in = 0;
    int n_fail = 0, comparisons = 0, cyc = 0, t, n_ts, n_ack, n_hold, n_err, n_oe;
    int nb[4] = '{1, 4, 2, 2};
    assign hready_in = hreadyout_out;
    assign transfer_acknowledge_pin_in = transfer_acknowledge_pin_oe_out ?
        transfer_acknowledge_pin_out : mta;
    dmc_default_memory u_dmc_default_memory (.*);
    dmc_mem_model #(.DATA(DATA)) u_dmc_mem_model (.clk_in, .ts_in(ext_ts_out),
        .cycle_in(ext_cycle_out), .ta_oe_in(transfer_acknowledge_pin_oe_out), .err_in(merr),
        .dly_in(mdly), .ta_out(mta), .tea_out(transfer_error_acknowledge_pin_in),
        .data_out(ext_data_in));
    initial forever #2.5 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        n_ts += ext_ts_out;
        n_ack += core_ack_out;
        n_err += core_err_out;
        n_hold += ext_addr_valid_out && !ext_cycle_out;
        n_oe += transfer_acknowledge_pin_oe_out;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            results();
        end
    end
    function automatic logic [15:0] cv(input logic [3:0] ws, input logic b, a,
        input logic [1:0] p, input logic e, wr, rd);
        return {2'h0, ws, b, a, p, e, 1'b0, wr, rd, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel_in <= 1; htrans_in <= 2'h2; haddr_in <= a; hwrite_in <= w;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        hsel_in <= 0; htrans_in <= 2'h0; hwdata_in <= d;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        q = hrdata_out;
    endtask
    task automatic xfer(input logic w, input logic [1:0] sz, input logic m = 0);
        n_ts = 0; n_ack = 0; n_hold = 0; n_err = 0; n_oe = 0; t = 1;
        core_write_in <= w; core_size_in <= sz; core_req_in <= !m; em_req_in <= m;
        @(posedge clk_in);
        core_req_in <= 0;
        do begin @(negedge clk_in); t++; end
        while ((m ? transfer_acknowledge_pin_out : core_last_out) !== 1'b1 && t < 100);
        @(posedge clk_in);
        em_req_in <= 0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        ahb(0, CTRL, 0); chk(q, 0);
        ahb(1, CTRL, 32'hffff); ahb(0, CTRL, 0); chk(q, 32'h3fec);
        ahb(0, 32'h100, 0); chk(q, 0);
        $display("register test done");
        ahb(1, CTRL, cv(2, 0, 1, 0, 0, 0, 0)); xfer(0, 0); chk(t, 6);
        chk(n_hold, 0);
        ahb(1, CTRL, cv(0, 0, 0, 0, 0, 0, 0)); mdly <= 2; xfer(0, 0); chk(t, 5);
        chk(core_rdata_out, DATA);
        ahb(1, CTRL, cv(15, 0, 1, 0, 0, 1, 0)); mdly <= 1; xfer(0, 0); chk(t, 4);
        merr <= 1; xfer(1, 0); chk(n_err, 1); chk(n_hold, 1);
        merr <= 0; mdly <= 0;
        $display("acknowledge test done");
        for (int p = 0; p < 4; p++) begin
            ahb(1, CTRL, cv(0, 0, 1, p[1:0], 0, 0, 0)); xfer(1, 0); chk(n_ts, nb[p]);
        end
        ahb(1, CTRL, cv(0, 1, 1, 1, 0, 0, 0)); xfer(0, 0); chk(n_ts, 1);
        ahb(1, CTRL, cv(0, 1, 1, 0, 0, 0, 1)); xfer(0, 3); chk(n_ack, 4);
        chk(n_ts, 1); chk(n_hold, 1);
        ahb(1, CTRL, cv(0, 0, 1, 0, 0, 0, 0)); xfer(0, 3); chk(n_ts, 4);
        $display("port test done");
        core_region_hit_in <= 1; core_req_in <= 1; n_ts = 0;
        repeat (10) @(posedge clk_in);
        chk(n_ts, 0);
        core_req_in <= 0; core_region_hit_in <= 0;
        @(posedge clk_in);
        ahb(1, CTRL, cv(3, 0, 0, 0, 1, 0, 0)); xfer(0, 0, 1); chk(t > 4, 1);
        chk(n_oe > 0, 1);
        ahb(1, CTRL, cv(3, 0, 0, 0, 0, 0, 0)); xfer(0, 0, 1); chk(n_oe, 0);
        $display("external master test done");
        results();
    end
endmodule
`default_nettype wire
